// ==== bench/hmu_regfile.sv ====
/*
 register file model taking the multiply unit's writes.
 assumes at most one registered write per clock from the unit.
*/
`timescale 1ns/1ps
`default_nettype none
module hmu_regfile (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic WR_EN,
    input wire logic [4:0] WR_DST,
    input wire logic [31:0] WR_DATA
);
    logic [31:0] regs_q [32];
    // take a write; untouched entries keep their value
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < 32; i++)
                regs_q[i] <= 32'h0000_0000;
        end else if (WR_EN) begin
            regs_q[WR_DST] <= WR_DATA;
        end
    end
endmodule // hmu_regfile
`default_nettype wire

// ==== bench/tb.sv ====
/*
 self-checking bench for the halfword multiply unit.
 assumes issue and operands are driven at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock = 1'b0, rst = 1'b1, issue = 1'b0, pred = 1'b0;
    logic [4:0] op = 5'h00, dst = 5'h00, wr_dst;
    logic [31:0] a = 32'h0, b = 32'h0, wr_data;
    logic wr_en, wr_uns, bad_op;
    int mismatches = 0, check_count = 0;
    // 25 MHz clock
    always #20 clock = ~clock;
    hmu_top dut_u (.CLOCK(clock), .RST(rst), .ISSUE(issue),
        .PRED_TRUE(pred), .OPCODE(op), .SRC1(a), .SRC2(b), .DST_IN(dst),
        .WR_EN(wr_en), .WR_DST(wr_dst), .WR_DATA(wr_data),
        .WR_UNSIGNED(wr_uns), .BAD_OP(bad_op));
    hmu_regfile rf_u (.CLOCK(clock), .RST(rst), .WR_EN(wr_en),
        .WR_DST(wr_dst), .WR_DATA(wr_data));
    // reference product; cst forms keep the constant signed
    function automatic logic [31:0] exp_mul(logic [4:0] o,
        logic [31:0] x, logic [31:0] y);
        logic [15:0] h1, h2;
        logic signed [16:0] e1, e2;
        logic signed [33:0] p;
        h1 = o[4] ? x[15:0] : x[31:16];
        h2 = o[3] ? y[15:0] : y[31:16];
        e1 = o[2] ? {1'b0, h1} : {h1[15], h1};
        e2 = o[1] ? {1'b0, h2} : {h2[15], h2};
        if (o == hmu_pkg::OP_LL_SS_CST || o == hmu_pkg::OP_LL_SU_CST)
            e1 = {{12{x[4]}}, x[4:0]};
        p = e1 * e2;
        return p[31:0];
    endfunction
    task automatic chk_word(input logic [31:0] got, input logic [31:0] e);
        check_count++;
        if (got !== e) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, e);
        end
    endtask
    task automatic chk_bit(input logic got, input logic e);
        chk_word({31'h0, got}, {31'h0, e});
    endtask
    task automatic drive(input logic i, input logic p, input logic [4:0] o,
        input logic [31:0] x, input logic [31:0] y, input logic [4:0] d);
        @(negedge clock);
        issue = i;
        pred = p;
        op = o;
        a = x;
        b = y;
        dst = d;
    endtask
    // every legal code back to back; result looked at two cycles on
    task automatic table_run();
        logic [4:0] o [20];
        logic [31:0] x [20], y [20];
        for (int i = 0; i < 20; i++) begin
            o[i] = (i < 16) ? 5'(2 * i + 1) : ((i == 16) ?
                hmu_pkg::OP_LL_SS_CST : hmu_pkg::OP_LL_SU_CST);
            x[i] = 32'h8003_fff3 + 32'(i) * 32'h0f01_1000;
            y[i] = 32'hfff5_8001 - 32'(i) * 32'h0102_0304;
            drive(i < 18, i < 18, o[i], x[i], y[i], 5'(i));
            if (i == 1)
                chk_bit(wr_en, 1'b0);
            if (i >= 2) begin
                chk_bit(wr_en, 1'b1);
                chk_word(wr_data, exp_mul(o[i-2], x[i-2], y[i-2]));
                chk_word({27'h0, wr_dst}, 32'(i - 2));
                chk_bit(wr_uns, i < 18 && o[i-2][2] && o[i-2][1]);
            end
        end
    endtask
    // false predicate must leave register three alone
    task automatic pred_false();
        logic [31:0] old;
        old = rf_u.regs_q[3];
        drive(1'b1, 1'b0, hmu_pkg::mul_low_low_signed, 32'h7fff,
            32'h7fff, 5'h03);
        repeat (3) begin
            drive(1'b0, 1'b0, 5'h00, 32'h0, 32'h0, 5'h00);
            chk_bit(wr_en, 1'b0);
        end
        chk_word(rf_u.regs_q[3], old);
    endtask
    // even code 00010 is refused with a pulse and no write
    task automatic bad_code();
        drive(1'b1, 1'b1, 5'h02, 32'h1234_5678, 32'h1234_5678, 5'h04);
        drive(1'b0, 1'b0, 5'h00, 32'h0, 32'h0, 5'h00);
        chk_bit(bad_op, 1'b1);
        drive(1'b0, 1'b0, 5'h00, 32'h0, 32'h0, 5'h00);
        chk_bit(bad_op, 1'b0);
        chk_bit(wr_en, 1'b0);
    endtask
    // worked examples with hand-computed products, run back to back
    task automatic doc_examples();
        logic [4:0] o [10];
        logic [31:0] x [10], y [10], e [10];
        logic [0:9] u;
        o = '{hmu_pkg::mul_low_low_signed, hmu_pkg::mul_low_low_unsigned,
            hmu_pkg::mul_low_low_uns_by_sgn, hmu_pkg::OP_LL_SS_CST,
            hmu_pkg::OP_LL_SU_CST, hmu_pkg::mul_high_high_signed,
            hmu_pkg::mul_high_high_unsigned, hmu_pkg::mul_high_high_sgn_by_uns,
            hmu_pkg::mul_high_low_signed, hmu_pkg::mul_low_high_signed};
        x = '{32'h0000_0123, 32'h0000_0123, 32'h1234_ffa1, 32'h0000_000d,
            32'h0000_000d, 32'h0023_0000, 32'h0023_0000, 32'h0023_0000,
            32'h008a_003e, 32'h0900_000e};
        y = '{32'h01e0_fa81, 32'h0f12_fa81, 32'h1234_ffa1, 32'h3497_fff3,
            32'h3497_fff3, 32'hffa7_1234, 32'hffa7_1234, 32'hffa7_ffff,
            32'h21ff_00a7, 32'h0029_00a7};
        e = '{32'hfff9_c0a3, 32'h011c_c0a3, 32'hffa1_2341, 32'hffff_ff57,
            32'h000c_ff57, 32'hffff_f3d5, 32'h0022_f3d5, 32'h0022_f3d5,
            32'h0000_5a06, 32'h0000_023e};
        u = 10'b0100001000;
        for (int i = 0; i < 12; i++) begin
            if (i < 10)
                drive(1'b1, 1'b1, o[i], x[i], y[i], 5'(i + 8));
            else
                drive(1'b0, 1'b0, 5'h00, 32'h0, 32'h0, 5'h00);
            if (i >= 2) begin
                chk_bit(wr_en, 1'b1);
                chk_word(wr_data, e[i-2]);
                chk_bit(wr_uns, u[i-2]);
            end
        end
    endtask
    // reset with a write in flight; next issue taken at the first edge
    task automatic mid_reset();
        drive(1'b1, 1'b1, hmu_pkg::mul_high_low_unsigned, 32'hffff_0000,
            32'h0000_ffff, 5'h07);
        drive(1'b0, 1'b0, 5'h00, 32'h0, 32'h0, 5'h00);
        rst = 1'b1;
        @(negedge clock);
        chk_bit(wr_en, 1'b0);
        chk_word(wr_data, hmu_pkg::RESULT_RESET);
        chk_word({27'h0, wr_dst}, {27'h0, hmu_pkg::DST_RESET});
        chk_bit(wr_uns, 1'b0);
        chk_bit(bad_op, 1'b0);
        rst = 1'b0;
        issue = 1'b1;
        pred = 1'b1;
        op = hmu_pkg::mul_high_high_unsigned;
        a = 32'hffff_0000;
        b = 32'hffff_0000;
        dst = 5'h09;
        drive(1'b0, 1'b0, 5'h00, 32'h0, 32'h0, 5'h00);
        chk_bit(wr_en, 1'b0);
        drive(1'b0, 1'b0, 5'h00, 32'h0, 32'h0, 5'h00);
        chk_bit(wr_en, 1'b1);
        chk_word(wr_data, 32'hfffe_0001);
        chk_word({27'h0, wr_dst}, 32'h0000_0009);
        chk_bit(wr_uns, 1'b1);
    endtask
    task automatic end_sim();
        if (mismatches == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (8) @(negedge clock);
        rst = 1'b0;
        table_run();
        doc_examples();
        pred_false();
        bad_code();
        mid_reset();
        end_sim();
    end
    // hang guard
    initial begin
        #100000;
        mismatches++;
        end_sim();
    end
endmodule // tb
`default_nettype wire

// ==== hw/hmu_pkg.sv ====
/*
 halfword multiply unit package: operation codes, field positions,
 widths and pipeline figures.
 assumes decode presents a 5-bit operation code with each issue.
*/
// Notes on behaviour
// RULE1: high-by-high codes 00001, 00111, 00101, 00011: upper halves of both.
// RULE2: high-by-low codes 01001, 01111, 01101, 01011: upper src1, lower src2.
// RULE3: low-by-high codes 10001, 10111, 10101, 10011: lower src1, upper src2.
// RULE4: a selected halfword is signed unless the code marks it unsigned.
// RULE5: 32-bit product written; unsigned only when both sources unsigned.
// RULE6: sources read in first execute phase, result visible two cycles later.
// RULE7: false predicate makes a no-operation; destination keeps its value.
// RULE8: low-by-low 11001, 11111, 11101, 11011; 11000, 11110 take signed cst5.
// RULE9: halfwords extend to 17 bits by signedness; low 32 product bits kept.
package hmu_pkg;
    localparam int OP_W = 5;
    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    localparam int CST_W = 5;
    localparam int LATENCY = 2;
    localparam int SEL1_BIT = 4;
    localparam int SEL2_BIT = 3;
    localparam int UNS1_BIT = 2;
    localparam int UNS2_BIT = 1;
    localparam int VALID_BIT = 0;
    localparam logic [OP_W-1:0] OP_LL_SS_CST = 5'h18;
    localparam logic [OP_W-1:0] OP_LL_SU_CST = 5'h1e;
    localparam logic [DATA_W-1:0] RESULT_RESET = 32'h0000_0000;
    localparam logic [4:0] DST_RESET = 5'h00;
    typedef enum logic [OP_W-1:0] {
        mul_high_high_signed = 5'h01,
        mul_high_high_sgn_by_uns = 5'h03,
        mul_high_high_uns_by_sgn = 5'h05,
        mul_high_high_unsigned = 5'h07,
        mul_high_low_signed = 5'h09,
        mul_high_low_sgn_by_uns = 5'h0b,
        mul_high_low_uns_by_sgn = 5'h0d,
        mul_high_low_unsigned = 5'h0f,
        mul_low_high_signed = 5'h11,
        mul_low_high_sgn_by_uns = 5'h13,
        mul_low_high_uns_by_sgn = 5'h15,
        mul_low_high_unsigned = 5'h17,
        mul_low_low_signed = 5'h19,
        mul_low_low_sgn_by_uns = 5'h1b,
        mul_low_low_uns_by_sgn = 5'h1d,
        mul_low_low_unsigned = 5'h1f
    } hmu_op_t;
endpackage

// ==== hw/hmu_top.sv ====
/*
 halfword multiply unit: 16x16 multiply with one delay slot.
 assumes decode drives operands, code and predicate in the issue cycle
 (first execute phase) and takes the write two cycles after issue.
*/
`timescale 1ns/1ps
`default_nettype none
module hmu_top (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic ISSUE,
    input wire logic PRED_TRUE,
    input wire logic [4:0] OPCODE,
    input wire logic [31:0] SRC1,
    input wire logic [31:0] SRC2,
    input wire logic [4:0] DST_IN,
    output logic WR_EN,
    output logic [4:0] WR_DST,
    output logic [31:0] WR_DATA,
    output logic WR_UNSIGNED,
    output logic BAD_OP
);
    // decode results, then e1 stage and e2 (write) stage registers
    logic legal;
    logic cst_form;
    logic uns1, uns2;
    logic [15:0] half1, half2;
    logic [16:0] ext1, ext2;
    logic [33:0] prod;
    logic go;
    logic e1_v_q, e1_v_d;
    logic [31:0] e1_p_q, e1_p_d;
    logic [4:0] e1_dst_q, e1_dst_d;
    logic e1_u_q, e1_u_d;
    logic wr_q, wr_d;
    logic [31:0] data_q, data_d;
    logic [4:0] dst_q, dst_d;
    logic u_q, u_d;
    logic bad_q, bad_d;

    // decode the code into halfword picks and signedness
    always_comb begin
        cst_form = (OPCODE == hmu_pkg::OP_LL_SS_CST) ||
            (OPCODE == hmu_pkg::OP_LL_SU_CST); // RULE8
        legal = OPCODE[hmu_pkg::VALID_BIT] || cst_form;
        // bit4 low picks src1 upper half, bit3 low picks src2 upper half
        half1 = OPCODE[hmu_pkg::SEL1_BIT] ? SRC1[15:0] : SRC1[31:16]; // RULE1
        half2 = OPCODE[hmu_pkg::SEL2_BIT] ? SRC2[15:0] : SRC2[31:16]; // RULE2
        if (cst_form) begin
            // signed 5-bit constant sits in src1 low bits
            half1 = {{11{SRC1[4]}}, SRC1[4:0]}; // RULE8
            uns1 = 1'b0;
            uns2 = (OPCODE == hmu_pkg::OP_LL_SU_CST);
        end else begin
            uns1 = OPCODE[hmu_pkg::UNS1_BIT]; // RULE4
            uns2 = OPCODE[hmu_pkg::UNS2_BIT]; // RULE4
        end
        // one 17-bit signed multiplier covers all four mixes
        ext1 = {half1[15] & ~uns1, half1}; // RULE9
        ext2 = {half2[15] & ~uns2, half2}; // RULE9
        prod = 34'($signed(ext1) * $signed(ext2));
    end

    // take an issue only when predicated true and the code is legal
    assign go = ISSUE && PRED_TRUE && legal; // RULE7

    // two-stage pipeline, e1 then e2 write
    always_comb begin
        e1_v_d = go; // RULE6
        e1_p_d = go ? prod[31:0] : e1_p_q; // RULE9
        e1_dst_d = go ? DST_IN : e1_dst_q;
        e1_u_d = go ? (uns1 && uns2) : e1_u_q; // RULE5
        wr_d = e1_v_q; // RULE6
        data_d = e1_v_q ? e1_p_q : data_q; // RULE7
        dst_d = e1_v_q ? e1_dst_q : dst_q;
        u_d = e1_v_q ? e1_u_q : u_q;
        bad_d = ISSUE && PRED_TRUE && !legal;
    end

    // registers only; held data avoids toggling the write bus when idle
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            e1_v_q <= 1'b0;
            e1_p_q <= hmu_pkg::RESULT_RESET;
            e1_dst_q <= hmu_pkg::DST_RESET;
            e1_u_q <= 1'b0;
            wr_q <= 1'b0;
            data_q <= hmu_pkg::RESULT_RESET;
            dst_q <= hmu_pkg::DST_RESET;
            u_q <= 1'b0;
            bad_q <= 1'b0;
        end else begin
            e1_v_q <= e1_v_d;
            e1_p_q <= e1_p_d;
            e1_dst_q <= e1_dst_d;
            e1_u_q <= e1_u_d;
            wr_q <= wr_d;
            data_q <= data_d;
            dst_q <= dst_d;
            u_q <= u_d;
            bad_q <= bad_d;
        end
    end

    // write outputs straight from the e2 registers, BAD_OP from the e1-stage bad_q
    assign WR_EN = wr_q;
    assign WR_DATA = data_q;
    assign WR_DST = dst_q;
    assign WR_UNSIGNED = u_q;
    assign BAD_OP = bad_q;

    // timing and qualification: a write follows a taken issue by exactly
    // two edges and never appears without one
    a_latency_two: assert property ( // RULE6
        @(posedge CLOCK) disable iff (RST)
        go |-> ##2 WR_EN)
        else $error("write did not follow issue by two cycles");
    a_write_source: assert property ( // RULE7
        @(posedge CLOCK) disable iff (RST)
        WR_EN |-> $past(go, 2))
        else $error("write without a taken issue two cycles before");
    a_pred_false_nop: assert property ( // RULE7
        @(posedge CLOCK) disable iff (RST)
        (ISSUE && !PRED_TRUE) |-> ##2 !WR_EN)
        else $error("false predicate produced a write");
    a_hold_value: assert property ( // RULE7
        @(posedge CLOCK) disable iff (RST)
        !WR_EN |-> WR_DATA == $past(WR_DATA) || $past(WR_EN))
        else $error("result changed without a write");
    a_dst_carry: assert property ( // RULE5
        @(posedge CLOCK) disable iff (RST)
        go |-> ##2 WR_DST == $past(DST_IN, 2))
        else $error("destination number not carried to the write");

    // product checks for each signedness mix and both constant forms; expected values come from
    // plain 16-bit arithmetic, not from the shared 17-bit multiplier
    a_hh_product: assert property ( // RULE1
        @(posedge CLOCK) disable iff (RST)
        (go && OPCODE == hmu_pkg::mul_high_high_signed) |-> ##2
        WR_DATA == $past(32'($signed(SRC1[31:16]) * $signed(SRC2[31:16])), 2))
        else $error("high by high signed product wrong");
    a_hh_unsigned: assert property ( // RULE1
        @(posedge CLOCK) disable iff (RST)
        (go && OPCODE == hmu_pkg::mul_high_high_unsigned) |-> ##2
        WR_DATA == $past(32'(SRC1[31:16] * SRC2[31:16]), 2))
        else $error("high by high unsigned product wrong");
    a_hh_mixed: assert property ( // RULE1
        @(posedge CLOCK) disable iff (RST)
        (go && OPCODE == hmu_pkg::mul_high_high_uns_by_sgn) |-> ##2
        WR_DATA == $past(32'($signed({1'b0, SRC1[31:16]}) *
        $signed(SRC2[31:16])), 2))
        else $error("high by high mixed product wrong");
    a_hl_unsigned: assert property ( // RULE2
        @(posedge CLOCK) disable iff (RST)
        (go && OPCODE == hmu_pkg::mul_high_low_unsigned) |-> ##2
        WR_DATA == $past(32'(SRC1[31:16] * SRC2[15:0]), 2))
        else $error("high by low unsigned product wrong");
    a_hl_signed: assert property ( // RULE2
        @(posedge CLOCK) disable iff (RST)
        (go && OPCODE == hmu_pkg::mul_high_low_signed) |-> ##2
        WR_DATA == $past(32'($signed(SRC1[31:16]) * $signed(SRC2[15:0])), 2))
        else $error("high by low signed product wrong");
    a_lh_mixed: assert property ( // RULE3
        @(posedge CLOCK) disable iff (RST)
        (go && OPCODE == hmu_pkg::mul_low_high_uns_by_sgn) |-> ##2
        WR_DATA == $past(32'($signed({1'b0, SRC1[15:0]}) *
        $signed(SRC2[31:16])), 2))
        else $error("low by high mixed product wrong");
    a_lh_unsigned: assert property ( // RULE3
        @(posedge CLOCK) disable iff (RST)
        (go && OPCODE == hmu_pkg::mul_low_high_unsigned) |-> ##2
        WR_DATA == $past(32'(SRC1[15:0] * SRC2[31:16]), 2))
        else $error("low by high unsigned product wrong");
    a_signed_default: assert property ( // RULE4
        @(posedge CLOCK) disable iff (RST)
        (go && OPCODE == hmu_pkg::mul_low_low_signed) |-> ##2
        WR_DATA == $past(32'($signed(SRC1[15:0]) * $signed(SRC2[15:0])), 2))
        else $error("low by low signed product wrong");
    a_ll_mixed: assert property ( // RULE4
        @(posedge CLOCK) disable iff (RST)
        (go && OPCODE == hmu_pkg::mul_low_low_sgn_by_uns) |-> ##2
        WR_DATA == $past(32'($signed(SRC1[15:0]) *
        $signed({1'b0, SRC2[15:0]})), 2))
        else $error("low by low mixed product wrong");
    a_cst_operand: assert property ( // RULE8
        @(posedge CLOCK) disable iff (RST)
        (go && OPCODE == hmu_pkg::OP_LL_SS_CST) |-> ##2
        WR_DATA == $past(32'($signed(SRC1[4:0]) * $signed(SRC2[15:0])), 2))
        else $error("constant form product wrong");
    a_cst_unsigned: assert property ( // RULE8
        @(posedge CLOCK) disable iff (RST)
        (go && OPCODE == hmu_pkg::OP_LL_SU_CST) |-> ##2
        WR_DATA == $past(32'($signed(SRC1[4:0]) *
        $signed({1'b0, SRC2[15:0]})), 2))
        else $error("constant by unsigned product wrong");

    // result flag, operand extension and refused codes
    a_unsigned_flag: assert property ( // RULE5
        @(posedge CLOCK) disable iff (RST)
        go |-> ##2 WR_UNSIGNED == $past(OPCODE[hmu_pkg::UNS1_BIT] &&
        OPCODE[hmu_pkg::UNS2_BIT] && OPCODE[hmu_pkg::VALID_BIT], 2))
        else $error("result signedness flag wrong");
    a_ext_width: assert property ( // RULE9
        @(posedge CLOCK) disable iff (RST)
        ext1[15:0] == half1 && (uns1 -> !ext1[16]) &&
        ext2[15:0] == half2 && (uns2 -> !ext2[16]))
        else $error("operand extension wrong");
    a_refused_code: assert property ( // RULE8
        @(posedge CLOCK) disable iff (RST)
        (ISSUE && PRED_TRUE && !legal) |-> ##1 BAD_OP ##1 !WR_EN)
        else $error("refused code did not pulse or still wrote");
    a_bad_quiet: assert property ( // RULE8
        @(posedge CLOCK) disable iff (RST)
        BAD_OP |-> $past(ISSUE && PRED_TRUE && !legal))
        else $error("refusal pulse without a refused issue");

    // scenario covers
    c_hh_signed: cover property (@(posedge CLOCK)
        go && OPCODE == hmu_pkg::mul_high_high_signed);
    c_back_to_back: cover property (@(posedge CLOCK)
        go ##1 go);
    c_pred_false: cover property (@(posedge CLOCK)
        ISSUE && !PRED_TRUE);
    c_cst_form: cover property (@(posedge CLOCK)
        go && OPCODE == hmu_pkg::OP_LL_SU_CST);
    c_refused: cover property (@(posedge CLOCK)
        ISSUE && PRED_TRUE && !legal);
endmodule // hmu_top
`default_nettype wire
